//--- logic/ssc_channel.v
/*
 Channel adapter of one processing system: status lines seen by the
 peer, remote reset, condition tests and character transfers in plain
 and marked mode out of a local character store, behind a classic
 Wishbone slave. Assumes the peer is an identical adapter on the same
 clock and that all link inputs are synchronous to CORE_CLK.
*/
`timescale 1ns/1ps
`include "ssc_consts.vh"
module ssc_channel (
    input wire CORE_CLK,
    input wire RST_N,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [9:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    output wire LNK_ERR_O,
    output wire LNK_EOT_O,
    output wire LNK_RDREQ_O,
    output wire LNK_WRREQ_O,
    output wire LNK_WRBSY_O,
    output wire LNK_RDBSY_O,
    output wire LNK_STOP_O,
    output reg LNK_DISC_O,
    output reg LNK_RRST_O,
    output reg LNK_TERR_O,
    output reg [6:0] LNK_DAT_O,
    output reg LNK_PAR_O,
    output reg LNK_DVAL_O,
    output reg LNK_DACK_O,
    input wire LNK_ERR_I,
    input wire LNK_EOT_I,
    input wire LNK_RDREQ_I,
    input wire LNK_WRREQ_I,
    input wire LNK_WRBSY_I,
    input wire LNK_RDBSY_I,
    input wire LNK_STOP_I,
    input wire LNK_DISC_I,
    input wire LNK_RRST_I,
    input wire LNK_TERR_I,
    input wire [6:0] LNK_DAT_I,
    input wire LNK_PAR_I,
    input wire LNK_DVAL_I,
    input wire LNK_DACK_I
);

localparam ST_IDLE = 5'h01;
localparam ST_WAIT = 5'h02;
localparam ST_FETCH = 5'h04;
localparam ST_XFER = 5'h08;
localparam ST_DONE = 5'h10;

reg [7:0] mem [0:63];
reg [4:0] state_reg;
reg [4:0] state_next;
reg [6:0] cnt_reg;
reg [5:0] start_reg;
reg [7:0] opsel_reg;
reg [7:0] badr_reg;
reg dir_w_reg;
reg load_reg;
reg halt_reg;
reg err_reg;
reg chk_reg;
reg eot_reg;
reg rdreq_reg;
reg wrreq_reg;
reg [3:0] test_cc_reg;
reg test_res_reg;
reg peer_bit;
reg [31:0] rdata;

wire wb_req = WB_CYC_I & WB_STB_I;
wire wb_wr = wb_req & WB_WE_I & WB_ACK_O;
wire [7:0] word = WB_ADR_I[9:2];
wire mem_sel = (WB_ADR_I[9:8] == `SSC_MEM_HI);
wire [31:0] bmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
    {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
wire [31:0] wd = WB_DAT_I & bmask;
wire [9:0] cp = (wb_wr && word == `SSC_A_CTRL) ? wd[9:0] : 10'h000;
wire test_wr = wb_wr && word == `SSC_A_TEST && WB_SEL_I[0];
wire st_idle = state_reg[0];
wire st_wait = state_reg[1];
wire st_fetch = state_reg[2];
wire st_xfer = state_reg[3];
wire st_done = state_reg[4];
wire sreset = cp[`SSC_C_SRST];
wire busy = st_wait | st_fetch | st_xfer;
wire [5:0] cur = start_reg + cnt_reg[5:0];
wire [7:0] cur_char = mem[cur];
// A stored terminator, or a full store, ends the transfer on this end.
wire term = cur_char[7] & (cur_char[5:0] == `SSC_GM_CODE);
wire endc = term | (cnt_reg == `SSC_DEPTH);
wire go = cp[`SSC_C_GO] & st_idle & ~halt_reg &
    (opsel_reg == `SSC_SEL_CODE);
wire go_w = cp[`SSC_C_DIRW];
wire peer_ready = dir_w_reg ? LNK_RDBSY_I : LNK_WRBSY_I;
// A character is accepted once; the one-cycle ack masks the held valid.
wire rx_take = st_xfer & ~dir_w_reg & LNK_DVAL_I & ~LNK_DACK_O;
wire tx_done = st_xfer & dir_w_reg & LNK_DACK_I;
wire rx_par_ok = ^{LNK_DAT_I, LNK_PAR_I};
wire rx_perr = rx_take & ~rx_par_ok;
wire rx_chk = ~^LNK_DAT_I[5:0];
wire [6:0] tx_dat = {load_reg & cur_char[7], cur_char[5:0]};
wire mem_bus_we = wb_wr & mem_sel & WB_SEL_I[0] & st_idle;
wire err_clr = chk_reg & (LNK_TERR_I | sreset);
wire eot_set = st_fetch & endc & ~sreset;

assign LNK_ERR_O = err_reg;
assign LNK_EOT_O = eot_reg;
assign LNK_RDREQ_O = rdreq_reg;
assign LNK_WRREQ_O = wrreq_reg;
assign LNK_WRBSY_O = busy & dir_w_reg;
assign LNK_RDBSY_O = busy & ~dir_w_reg;
assign LNK_STOP_O = halt_reg;

always @* begin
    state_next = state_reg;
    case (state_reg)
        ST_IDLE: begin
            if (go) begin
                state_next = eot_reg ? ST_DONE : ST_WAIT;
            end
        end
        ST_WAIT: begin
            if (sreset) begin
                state_next = ST_IDLE;
            end else if (peer_ready) begin
                state_next = ST_FETCH;
            end
        end
        ST_FETCH: begin
            if (sreset) begin
                state_next = ST_IDLE;
            end else if (endc) begin
                state_next = ST_DONE;
            end else begin
                state_next = ST_XFER;
            end
        end
        ST_XFER: begin
            if (sreset) begin
                state_next = ST_IDLE;
            end else if (LNK_DISC_I) begin
                state_next = ST_DONE;
            end else if (tx_done | rx_take) begin
                state_next = ST_FETCH;
            end
        end
        ST_DONE: begin
            state_next = ST_IDLE;
        end
        default: begin
            state_next = ST_IDLE;
        end
    endcase
end

always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
        state_reg <= `SSC_RST_ST;
        cnt_reg <= 7'h00;
        dir_w_reg <= 1'b0;
        load_reg <= 1'b0;
        badr_reg <= 8'h00;
    end else begin
        state_reg <= state_next;
        if (go) begin
            cnt_reg <= 7'h00;
            dir_w_reg <= go_w;
            load_reg <= cp[`SSC_C_LOAD];
        end else if (rx_take | tx_done) begin
            cnt_reg <= cnt_reg + 7'h01;
        end
        if (st_done) begin
            badr_reg <= {2'h0, start_reg} + {1'b0, cnt_reg} + 8'h01;
        end
    end
end

// The store is data only and carries no reset.
always @(posedge CORE_CLK) begin
    if (mem_bus_we) begin
        mem[WB_ADR_I[7:2]] <= WB_DAT_I[7:0];
    end else if (rx_take) begin
        mem[cur] <= {load_reg ? LNK_DAT_I[6] : cur_char[7], rx_chk,
            LNK_DAT_I[5:0]};
    end
end

always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
        LNK_DAT_O <= 7'h00;
        LNK_PAR_O <= 1'b1;
        LNK_DVAL_O <= 1'b0;
        LNK_DACK_O <= 1'b0;
        LNK_DISC_O <= 1'b0;
    end else begin
        if (st_fetch & dir_w_reg) begin
            LNK_DAT_O <= tx_dat;
            LNK_PAR_O <= ~^tx_dat;
        end
        LNK_DVAL_O <= dir_w_reg & (state_next == ST_XFER);
        LNK_DACK_O <= rx_take;
        LNK_DISC_O <= eot_set;
    end
end

always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
        err_reg <= 1'b0;
        chk_reg <= 1'b0;
        eot_reg <= 1'b0;
        rdreq_reg <= 1'b0;
        wrreq_reg <= 1'b0;
        halt_reg <= 1'b0;
    end else begin
        if (rx_perr) begin
            err_reg <= 1'b1;
        end else if (err_clr) begin
            err_reg <= 1'b0;
        end
        if (cp[`SSC_C_CHKRST] & err_reg) begin
            chk_reg <= 1'b1;
        end else if (err_clr & ~rx_perr) begin
            chk_reg <= 1'b0;
        end
        if (eot_set) begin
            eot_reg <= 1'b1;
        end else if (LNK_RRST_I | sreset) begin
            eot_reg <= 1'b0;
        end
        if (cp[`SSC_C_RDREQ]) begin
            rdreq_reg <= 1'b1;
        end else if ((go & go_w) | sreset) begin
            rdreq_reg <= 1'b0;
        end
        if (cp[`SSC_C_WRREQ]) begin
            wrreq_reg <= 1'b1;
        end else if ((go & ~go_w) | sreset) begin
            wrreq_reg <= 1'b0;
        end
        // An error stops the processor only once the transfer has ended.
        if (cp[`SSC_C_STOP] | (st_done & err_reg)) begin
            halt_reg <= 1'b1;
        end else if (cp[`SSC_C_START]) begin
            halt_reg <= 1'b0;
        end
    end
end

always @* begin
    case (test_cc_reg)
        `SSC_CC_ERR: peer_bit = LNK_ERR_I;
        `SSC_CC_EOT: peer_bit = LNK_EOT_I;
        `SSC_CC_RDREQ: peer_bit = LNK_RDREQ_I;
        `SSC_CC_WRREQ: peer_bit = LNK_WRREQ_I;
        `SSC_CC_WRBSY: peer_bit = LNK_WRBSY_I;
        `SSC_CC_RDBSY: peer_bit = LNK_RDBSY_I;
        `SSC_CC_STOP: peer_bit = LNK_STOP_I;
        default: peer_bit = 1'b0;
    endcase
end

// The test samples one cycle after the code is written, so the result
// matches the stored code from the second cycle after the write on.
always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
        test_cc_reg <= 4'h0;
        test_res_reg <= 1'b0;
        LNK_TERR_O <= 1'b0;
        LNK_RRST_O <= 1'b0;
        opsel_reg <= 8'h00;
        start_reg <= 6'h00;
    end else begin
        if (test_wr) begin
            test_cc_reg <= WB_DAT_I[3:0];
        end
        test_res_reg <= peer_bit;
        LNK_TERR_O <= test_wr & (WB_DAT_I[3:0] == `SSC_CC_ERR);
        LNK_RRST_O <= cp[`SSC_C_RRST];
        if (wb_wr && word == `SSC_A_OPER && st_idle) begin
            if (WB_SEL_I[0]) begin
                opsel_reg <= WB_DAT_I[7:0];
            end
            if (WB_SEL_I[1]) begin
                start_reg <= WB_DAT_I[13:8];
            end
        end
    end
end

always @* begin
    rdata = 32'h00000000;
    if (mem_sel) begin
        rdata = {24'h000000, mem[WB_ADR_I[7:2]]};
    end else begin
        case (word)
            `SSC_A_CTRL: rdata = {22'h000000, dir_w_reg, load_reg,
                3'h0, state_reg};
            `SSC_A_OPER: rdata = {18'h00000, start_reg, opsel_reg};
            `SSC_A_BADR: rdata = {24'h000000, badr_reg};
            `SSC_A_TEST: rdata = {23'h000000, test_res_reg, 4'h0,
                test_cc_reg};
            `SSC_A_STAT: rdata = {12'h000, 2'h0, busy, halt_reg, 1'b0,
                LNK_STOP_I, LNK_RDBSY_I, LNK_WRBSY_I, LNK_WRREQ_I,
                LNK_RDREQ_I, LNK_EOT_I, LNK_ERR_I, 1'b0, LNK_STOP_O,
                LNK_RDBSY_O, LNK_WRBSY_O, wrreq_reg, rdreq_reg,
                eot_reg, err_reg};
            default: rdata = 32'h00000000;
        endcase
    end
end

always @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
        WB_ACK_O <= 1'b0;
        WB_DAT_O <= 32'h00000000;
    end else begin
        WB_ACK_O <= wb_req & ~WB_ACK_O;
        if (wb_req & ~WB_ACK_O) begin
            WB_DAT_O <= rdata;
        end
    end
end

endmodule // ssc_channel

//--- logic/ssc_consts.vh
/*
 Constants for the system-to-system character channel: register map,
 control bit positions, condition codes, storage size and reset values.
 Assumes inclusion by bare name from the channel module.
*/
// Summary of operation
// - Local parity error raises the error line; once check-reset is given, cleared by peer test or start-reset.
// - Own terminator mark ends transfer, pulses disconnect and sets end-of-transmission.
// - End-of-transmission clears by peer remote reset or local start-reset.
// - Read-request op sets a line; write transfer or start-reset clears it.
// - Write-request op sets a line; read transfer or start-reset clears it.
// - Write-busy line stands while a write transfer is active.
// - Read-busy line stands while a read transfer is active.
// - Transfer ends at once, moving nothing, while end-of-transmission is set.
// - Stopped line stands while the processor is halted.
// - Plain transfers carry check, zone and numeric bits, never the word mark.
// - Marked transfers carry the word mark as well.
// - Both ends use one mode; marked sender to plain receiver loses marks.
// - Transfer runs only with the channel select code; start address given.
// - Direction bit: receive from the peer, or send to the peer.
// - Plain receive stores upward from start and keeps stored marks untouched.
// - Marked receive replaces stored word marks with the arriving ones.
// - Plain send transmits characters from start without word marks.
// - Marked send transmits word marks with their characters.
// - After a transfer the end address is start plus length plus one.
// - One character at a time, all bits parallel, with odd parity.
`ifndef SSC_CONSTS_VH
`define SSC_CONSTS_VH
`define SSC_A_CTRL 8'h00
`define SSC_A_OPER 8'h01
`define SSC_A_BADR 8'h02
`define SSC_A_TEST 8'h03
`define SSC_A_STAT 8'h04
`define SSC_MEM_HI 2'h1
`define SSC_C_RDREQ 0
`define SSC_C_WRREQ 1
`define SSC_C_RRST 2
`define SSC_C_GO 3
`define SSC_C_LOAD 4
`define SSC_C_DIRW 5
`define SSC_C_SRST 6
`define SSC_C_CHKRST 7
`define SSC_C_STOP 8
`define SSC_C_START 9
`define SSC_CC_ERR 4'h1
`define SSC_CC_EOT 4'h2
`define SSC_CC_RDREQ 4'h3
`define SSC_CC_WRREQ 4'h4
`define SSC_CC_WRBSY 4'h6
`define SSC_CC_RDBSY 4'h7
`define SSC_CC_STOP 4'h8
`define SSC_SEL_CODE 8'h25
`define SSC_GM_CODE 6'h3f
`define SSC_DEPTH 7'h40
`define SSC_RST_ST 5'h01
`endif

//--- sim/ssc_channel_checker.sv
/* Port checker for the channel adapter.
   Assumes it is bound to every instance of ssc_channel. */
`timescale 1ns/1ps
module ssc_channel_checker (
    input wire CORE_CLK,
    input wire RST_N,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_ACK_O,
    input wire LNK_EOT_O,
    input wire LNK_WRBSY_O,
    input wire LNK_RDBSY_O,
    input wire LNK_DISC_O,
    input wire [6:0] LNK_DAT_O,
    input wire LNK_PAR_O,
    input wire LNK_DVAL_O,
    input wire LNK_DACK_O,
    input wire LNK_DACK_I,
    input wire LNK_DISC_I
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    property p_ack; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
    property p_ack1; WB_ACK_O |=> !WB_ACK_O; endproperty
    property p_disc; LNK_DISC_O |-> ##[0:1] LNK_EOT_O; endproperty
    property p_par; LNK_DVAL_O |-> ^{LNK_DAT_O, LNK_PAR_O}; endproperty
    property p_hold;
        LNK_DVAL_O && !LNK_DACK_I && !LNK_DISC_I |=>
            LNK_DVAL_O && $stable(LNK_DAT_O);
    endproperty
    property p_drop; LNK_DVAL_O && LNK_DACK_I |=> !LNK_DVAL_O; endproperty
    property p_dack; LNK_DACK_O |-> $past(LNK_RDBSY_O); endproperty
    property p_excl; !(LNK_WRBSY_O && LNK_RDBSY_O); endproperty
    property p_wrdv; $rose(LNK_DVAL_O) |-> LNK_WRBSY_O; endproperty
    a_ack: assert property (p_ack) else $error("ack late");
    a_ack1: assert property (p_ack1) else $error("ack long");
    a_disc: assert property (p_disc) else $error("no eot");
    a_par: assert property (p_par) else $error("parity");
    a_hold: assert property (p_hold) else $error("char moved");
    a_drop: assert property (p_drop) else $error("valid kept");
    a_dack: assert property (p_dack) else $error("stray accept");
    a_excl: assert property (p_excl) else $error("both busy");
    a_wrdv: assert property (p_wrdv) else $error("send idle");
    c_send: cover property (LNK_DVAL_O && LNK_DACK_I);
    c_recv: cover property (LNK_DACK_O);
    c_disc: cover property (LNK_DISC_O);
endmodule // ssc_channel_checker
bind ssc_channel ssc_channel_checker CHK (.CORE_CLK(CORE_CLK),
    .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_ACK_O(WB_ACK_O), .LNK_EOT_O(LNK_EOT_O),
    .LNK_WRBSY_O(LNK_WRBSY_O), .LNK_RDBSY_O(LNK_RDBSY_O),
    .LNK_DISC_O(LNK_DISC_O), .LNK_DAT_O(LNK_DAT_O),
    .LNK_PAR_O(LNK_PAR_O), .LNK_DVAL_O(LNK_DVAL_O),
    .LNK_DACK_O(LNK_DACK_O), .LNK_DACK_I(LNK_DACK_I),
    .LNK_DISC_I(LNK_DISC_I));

//--- sim/ssc_peer.sv
/* Peer adapter model: status levels from pv, receives characters,
   sends three characters then disconnects.
   Assumes the bench owns pv and the same clock as the adapter. */
`timescale 1ns/1ps
module ssc_peer (
    input wire CORE_CLK,
    input wire RST_N,
    input wire [7:0] pv,
    input wire bad,
    input wire rdbsy_i,
    input wire [6:0] dat_i,
    input wire par_i,
    input wire dval_i,
    input wire dack_i,
    output wire [6:0] lv,
    output reg disc,
    output reg [6:0] dat_o,
    output reg par_o,
    output reg dval_o,
    output reg dack_o
);
    reg [7:0] rx [0:7];
    int nrx;
    int ntx;
    wire [6:0] ch = 7'(7'h11 + ntx) | ((ntx == 1) ? 7'h40 : 7'h00);
    assign lv = pv[6:0];
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            {disc, dat_o, par_o, dval_o, dack_o} <= 11'h004;
            nrx <= 0;
            ntx <= 0;
        end else begin
            dack_o <= pv[5] && dval_i && !dack_o;
            disc <= !dval_o && pv[4] && rdbsy_i && ntx == 3;
            if (!pv[5])
                nrx <= 0;
            else if (dval_i && !dack_o) begin
                rx[nrx[2:0]] <= {par_i, dat_i};
                nrx <= nrx + 1;
            end
            if (!pv[4])
                ntx <= 0;
            else if (dval_o && dack_i)
                ntx <= ntx + 1;
            else if (!dval_o && rdbsy_i && ntx == 3)
                ntx <= 4;
            if (dval_o && dack_i) begin
                dval_o <= 1'b0;
            end else if (!dval_o) begin
                if (pv[4] && rdbsy_i && ntx < 3) begin
                    dval_o <= 1'b1;
                    dat_o <= ch;
                    par_o <= ~^ch ^ (bad && ntx == 2);
                end else begin
                    // Released lines wander so a stale character never passes.
                    dat_o <= ~dat_o;
                end
            end
        end
    end
endmodule // ssc_peer

//--- sim/ssc_channel_tb.sv
/* Bench for ssc_channel: condition-test table, then requests, sends,
   receives and a parity fault. Assumes the peer model and checker. */
`timescale 1ns/1ps
`include "ssc_consts.vh"
module ssc_channel_tb;
    typedef struct {logic [3:0] c; logic [7:0] p;} ssc_row_t;
    ssc_row_t rows [7] = '{'{4'h1, 8'h01}, '{4'h2, 8'h02},
        '{4'h3, 8'h04}, '{4'h4, 8'h08}, '{4'h6, 8'h10},
        '{4'h7, 8'h20}, '{4'h8, 8'h40}};
    logic [7:0] img [4] = '{8'h05, 8'h86, 8'h07, 8'hbf};
    logic clk = 0, rst_n = 0, cyc = 0, we = 0, bad = 0, terr = 0;
    logic [9:0] adr = 0;
    logic [31:0] dat = 0, q;
    logic [7:0] pv = 0;
    logic [6:0] e;
    logic [5:0] b;
    int err_count = 0, checks_done = 0;
    int n_rrs = 0, n_ter = 0;
    wire [31:0] rd;
    wire [6:0] lv, ddat, pdat;
    wire ack, err, eot, rq, wq, wbs, rbs, stp, dpar, ddv, ddk;
    wire pdisc, ppar, pdv, pdk, rrs, ters;
    always #25 clk = ~clk;
    // Remote-reset and error-test pulses last one cycle, so count them.
    always @(posedge clk) begin
        n_rrs <= n_rrs + rrs;
        n_ter <= n_ter + ters;
    end
    ssc_channel DUT (.CORE_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc),
        .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
        .WB_DAT_I(dat), .WB_DAT_O(rd), .WB_ACK_O(ack), .LNK_ERR_O(err),
        .LNK_EOT_O(eot), .LNK_RDREQ_O(rq), .LNK_WRREQ_O(wq),
        .LNK_WRBSY_O(wbs), .LNK_RDBSY_O(rbs), .LNK_STOP_O(stp),
        .LNK_DISC_O(), .LNK_RRST_O(rrs), .LNK_TERR_O(ters),
        .LNK_DAT_O(ddat),
        .LNK_PAR_O(dpar), .LNK_DVAL_O(ddv), .LNK_DACK_O(ddk),
        .LNK_ERR_I(lv[0]), .LNK_EOT_I(lv[1]), .LNK_RDREQ_I(lv[2]),
        .LNK_WRREQ_I(lv[3]), .LNK_WRBSY_I(lv[4]), .LNK_RDBSY_I(lv[5]),
        .LNK_STOP_I(lv[6]), .LNK_DISC_I(pdisc), .LNK_RRST_I(pv[7]),
        .LNK_TERR_I(terr), .LNK_DAT_I(pdat), .LNK_PAR_I(ppar),
        .LNK_DVAL_I(pdv), .LNK_DACK_I(pdk));
    ssc_peer P (.CORE_CLK(clk), .RST_N(rst_n), .pv(pv), .bad(bad),
        .rdbsy_i(rbs), .dat_i(ddat), .par_i(dpar), .dval_i(ddv),
        .dack_i(ddk), .lv(lv), .disc(pdisc), .dat_o(pdat),
        .par_o(ppar), .dval_o(pdv), .dack_o(pdk));
    task print_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task fail();
        err_count++;
        print_verdict();
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        checks_done++;
        if (g !== x) begin
            err_count++;
            $display("BAD t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= {a, 2'b00};
        dat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rd;
        cyc <= 1'b0;
        if (n >= 20)
            fail();
        // Two falling edges let level outputs settle before any check.
        repeat (2) @(negedge clk);
    endtask
    task setp(input logic [7:0] v);
        @(posedge clk);
        pv <= v;
    endtask
    task tterr();
        @(posedge clk);
        terr <= 1'b1;
        @(posedge clk);
        terr <= 1'b0;
        @(negedge clk);
    endtask
    task idle();
        int n;
        n = 0;
        do begin
            wb(0, `SSC_A_CTRL, 0);
            n++;
        end while (q[4:0] !== 5'h01 && n < 100);
        if (n >= 100)
            fail();
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        chk({err, eot, rq, wq, wbs, rbs, stp, dpar}, 8'h01);
        wb(0, `SSC_A_CTRL, 0);
        chk(q[4:0], 5'h01);
        $display("end reset");
        foreach (rows[i]) begin
            setp(rows[i].p);
            wb(0, `SSC_A_STAT, 0);
            chk(q[17:0], {3'h0, rows[i].p[6:0], 8'h00});
            wb(1, `SSC_A_TEST, rows[i].c);
            wb(0, `SSC_A_TEST, 0);
            chk({q[8], q[3:0]}, {1'b1, rows[i].c});
            setp(8'h00);
            wb(1, `SSC_A_TEST, rows[i].c);
            wb(0, `SSC_A_TEST, 0);
            chk(q[8], 1'b0);
            chk({err, eot, rq, wq, stp}, 5'h00);
        end
        chk(n_ter, 2);
        $display("end rows");
        wb(1, `SSC_A_CTRL, 32'h004);
        chk(n_rrs, 1);
        wb(1, `SSC_A_CTRL, 32'h001);
        chk(rq, 1'b1);
        wb(1, `SSC_A_CTRL, 32'h002);
        chk({rq, wq}, 2'b11);
        wb(1, `SSC_A_CTRL, 32'h040);
        chk({rq, wq}, 2'b00);
        wb(1, `SSC_A_CTRL, 32'h100);
        chk(stp, 1'b1);
        wb(1, `SSC_A_CTRL, 32'h200);
        chk(stp, 1'b0);
        $display("end requests");
        foreach (img[i]) wb(1, 8'(8'h41 + i), 32'(img[i]));
        wb(1, `SSC_A_OPER, 32'h0124);
        wb(1, `SSC_A_CTRL, 32'h028);
        chk(wbs, 1'b0);
        for (int m = 0; m < 2; m++) begin
            setp(8'h20);
            wb(1, `SSC_A_OPER, 32'h0125);
            wb(1, `SSC_A_CTRL, m ? 32'h038 : 32'h028);
            idle();
            chk(P.nrx, 3);
            for (int k = 0; k < 3; k++) begin
                e = {img[k][7] & m[0], img[k][5:0]};
                chk(P.rx[k], {~^e, e});
            end
            chk(eot, 1'b1);
            wb(0, `SSC_A_BADR, 0);
            chk(q[7:0], 8'h05);
            wb(1, `SSC_A_CTRL, 32'h028);
            idle();
            wb(0, `SSC_A_BADR, 0);
            chk({P.nrx[7:0], q[7:0]}, 16'h0302);
            setp(8'h80);
            setp(8'h00);
            @(negedge clk);
            chk(eot, 1'b0);
        end
        $display("end send");
        for (int m = 0; m < 2; m++) begin
            foreach (img[i]) wb(1, 8'(8'h4a + i), 32'h080);
            setp(8'h10);
            wb(1, `SSC_A_OPER, 32'h0a25);
            wb(1, `SSC_A_CTRL, m ? 32'h018 : 32'h008);
            idle();
            for (int k = 0; k < 3; k++) begin
                b = 6'(6'h11 + k);
                wb(0, 8'(8'h4a + k), 0);
                chk(q[7:0], {m[0] ? k == 1 : 1'b1, ~^b, b});
            end
            wb(0, `SSC_A_BADR, 0);
            chk(q[7:0], 8'h0e);
            setp(8'h00);
        end
        $display("end receive");
        bad <= 1'b1;
        // First pass clears the error by start-reset, second by peer test.
        for (int m = 0; m < 2; m++) begin
            setp(8'h10);
            wb(1, `SSC_A_CTRL, 32'h008);
            idle();
            chk({err, stp}, 2'b11);
            tterr();
            chk(err, 1'b1);
            wb(1, `SSC_A_CTRL, 32'h080);
            if (m)
                tterr();
            else
                wb(1, `SSC_A_CTRL, 32'h040);
            chk(err, 1'b0);
            wb(1, `SSC_A_CTRL, 32'h200);
            setp(8'h00);
        end
        $display("end fault");
        print_verdict();
    end
endmodule // ssc_channel_tb
